// file: pkg/ccs_defs.svh
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
`define CCS_CLK_MHZ 100
`define CCS_PRE_TIMER_MIN 32
`define CCS_PRE_TIMER_CYC (64'(`CCS_PRE_TIMER_MIN) * 60 * 1000000 * `CCS_CLK_MHZ)
`define CCS_FAULT_FLASH_MS 1600
`define CCS_FAULT_HALF_CYC (`CCS_FAULT_FLASH_MS * 1000 * `CCS_CLK_MHZ / 2)
`define CCS_TERM_FILT_MS 1
`define CCS_TERM_FILT_CYC (`CCS_TERM_FILT_MS * 1000 * `CCS_CLK_MHZ)
`define CCS_TERM_SEL_RST 2'h0
`endif

// file: pkg/ccs_pkg.sv
package ccs_pkg;
  typedef struct packed {
    logic input_low_lockout;
    logic input_high_lockout;
    logic headroom_ok;
    logic power_down;
    logic below_start;
    logic below_precondition;
    logic below_recharge;
    logic at_regulation;
    logic over_regulation;
    logic program_floating;
    logic below_termination;
  } ccs_cmp_t;

  typedef enum logic [6:0] {
    CCS_SHUTDOWN = 7'h01,
    CCS_STANDBY = 7'h02,
    CCS_PRECOND = 7'h04,
    CCS_CONST_CURRENT = 7'h08,
    CCS_CONST_VOLTAGE = 7'h10,
    CCS_COMPLETE = 7'h20,
    CCS_FAULT = 7'h40
  } ccs_state_t;

  typedef struct packed {
    logic charge_on;
    logic precondition_current;
    logic voltage_mode;
    logic timer_fault;
  } ccs_drive_t;
endpackage : ccs_pkg

// file: logic/ccs_sync.sv
`timescale 1ns/10ps
module ccs_sync #(
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw and synchronised flags
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // comparators are analog and asynchronous; first stage feeds second only
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;
endmodule : ccs_sync

// file: logic/ccs_sequencer.sv
`timescale 1ns/10ps
`include "ccs_defs.svh"
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter longint PRE_TIMER_CYC = `CCS_PRE_TIMER_CYC,
  parameter longint FLASH_HALF_CYC = `CCS_FAULT_HALF_CYC,
  parameter longint TERM_FILT_CYC = `CCS_TERM_FILT_CYC,
  parameter bit PRE_TIMER_EN = 1'b1,
  parameter bit PRECOND_EN = 1'b1,
  parameter bit RECHARGE_EN = 1'b1,
  parameter bit FLASH_FAULT = 1'b1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // analog comparator flags, asynchronous
  input wire ccs_pkg::ccs_cmp_t cmp_in,
  input wire logic charge_enable_in,
  // fast-charge safety timer expiry from outside timer
  input wire logic charge_timer_done_in,
  // charge control
  output ccs_pkg::ccs_drive_t drive_out,
  output logic charge_timer_clear_out,
  output ccs_pkg::ccs_state_t state_out,
  // open-drain status pin: oe low pulls pin low
  output logic status_o_out,
  output logic status_oe_n_out
);
  import ccs_pkg::*;

  ccs_cmp_t cmp_s;
  logic en_meta_q;
  logic en_q;
  ccs_state_t state_q;
  ccs_state_t state_d;
  logic [37:0] pre_cnt_q;
  logic pre_expired;
  logic [27:0] flash_cnt_q;
  logic flash_q;
  logic [17:0] term_cnt_q;
  logic term_done;
  logic supply_bad;
  logic pre_fault_q;

  ccs_sync #(
    .WIDTH($bits(ccs_cmp_t))
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(cmp_in),
    .sync_out(cmp_s)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      en_meta_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      en_meta_q <= charge_enable_in;
      en_q <= en_meta_q;
    end
  end

  // lockout, overvoltage, headroom and power-down share one path out
  assign supply_bad = cmp_s.input_low_lockout | cmp_s.input_high_lockout | cmp_s.power_down
                      | ~cmp_s.headroom_ok;
  assign pre_expired = PRE_TIMER_EN && (pre_cnt_q >= 38'(PRE_TIMER_CYC - 1));
  assign term_done = (term_cnt_q >= 18'(TERM_FILT_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      CCS_SHUTDOWN: begin
        if (!supply_bad) begin
          state_d = CCS_STANDBY;
        end
      end
      CCS_STANDBY: begin
        // start needs enable, connected program pin, below start and recharge
        if (en_q && !cmp_s.program_floating && cmp_s.below_start && cmp_s.below_recharge
            && !cmp_s.over_regulation) begin
          if (PRECOND_EN && cmp_s.below_precondition) begin
            state_d = CCS_PRECOND;
          end else begin
            state_d = CCS_CONST_CURRENT;
          end
        end
      end
      CCS_PRECOND: begin
        if (pre_expired) begin
          state_d = CCS_FAULT;
        end else if (!cmp_s.below_precondition) begin
          state_d = CCS_CONST_CURRENT;
        end
      end
      CCS_CONST_CURRENT: begin
        if (charge_timer_done_in) begin
          state_d = CCS_FAULT;
        end else if (cmp_s.at_regulation) begin
          state_d = CCS_CONST_VOLTAGE;
        end
      end
      CCS_CONST_VOLTAGE: begin
        if (term_done || charge_timer_done_in) begin
          state_d = RECHARGE_EN ? CCS_COMPLETE : CCS_STANDBY;
        end
      end
      CCS_COMPLETE: begin
        if (RECHARGE_EN && cmp_s.below_recharge && !cmp_s.over_regulation) begin
          state_d = CCS_CONST_CURRENT;
        end
      end
      CCS_FAULT: begin
        // removal shows as battery node floating up past recharge threshold
        if (!cmp_s.below_recharge) begin
          state_d = CCS_STANDBY;
        end
      end
      default: begin
        state_d = CCS_SHUTDOWN;
      end
    endcase
    // charging states drop out on overcharge or floating program pin
    if ((state_q == CCS_PRECOND || state_q == CCS_CONST_CURRENT || state_q == CCS_CONST_VOLTAGE)
        && (cmp_s.over_regulation || cmp_s.program_floating || !en_q)) begin
      state_d = CCS_STANDBY;
    end
    if (supply_bad) begin
      state_d = CCS_SHUTDOWN;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CCS_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // precondition timer, cleared whenever not preconditioning
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_cnt_q <= '0;
    end else if (state_q != CCS_PRECOND) begin
      pre_cnt_q <= '0;
    end else if (!pre_expired) begin
      pre_cnt_q <= pre_cnt_q + 38'h1;
    end
  end

  // termination filter restarts on any gap in the comparator
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      term_cnt_q <= '0;
    end else if (state_q != CCS_CONST_VOLTAGE || !cmp_s.below_termination) begin
      term_cnt_q <= '0;
    end else if (!term_done) begin
      term_cnt_q <= term_cnt_q + 18'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_fault_q <= 1'b0;
    end else if (state_d == CCS_SHUTDOWN || state_d == CCS_STANDBY) begin
      pre_fault_q <= 1'b0;
    end else if (state_d == CCS_FAULT) begin
      pre_fault_q <= 1'b1;
    end
  end

  // flash time base free-runs only in fault
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (state_q != CCS_FAULT) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q >= 28'(FLASH_HALF_CYC - 1)) begin
      flash_cnt_q <= '0;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + 28'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      drive_out <= '0;
      charge_timer_clear_out <= 1'b1;
      state_out <= CCS_SHUTDOWN;
      status_o_out <= 1'b0;
      status_oe_n_out <= 1'b1;
    end else begin
      drive_out.charge_on <= state_d inside {CCS_PRECOND, CCS_CONST_CURRENT, CCS_CONST_VOLTAGE};
      drive_out.precondition_current <= (state_d == CCS_PRECOND);
      drive_out.voltage_mode <= (state_d == CCS_CONST_VOLTAGE);
      // fault flag drops in the same cycle shutdown or standby is entered
      drive_out.timer_fault <= (pre_fault_q && !(state_d inside {CCS_SHUTDOWN, CCS_STANDBY}))
                               || (state_d == CCS_FAULT);
      // clear on entry to constant current and throughout shutdown
      charge_timer_clear_out <= (state_d == CCS_CONST_CURRENT && state_q != CCS_CONST_CURRENT)
                                || state_d == CCS_SHUTDOWN;
      state_out <= state_d;
      status_o_out <= 1'b0;
      if (state_d inside {CCS_PRECOND, CCS_CONST_CURRENT, CCS_CONST_VOLTAGE}) begin
        status_oe_n_out <= 1'b0;
      end else if (state_d == CCS_FAULT && FLASH_FAULT) begin
        status_oe_n_out <= ~flash_q;
      end else begin
        status_oe_n_out <= 1'b1;
      end
    end
  end

  shut_supply_a: assert property (@(posedge clk_in) disable iff (rst_in)
    supply_bad |=> state_q == CCS_SHUTDOWN) else $error("supply fault did not force shutdown");
  pre_path_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_PRECOND && !supply_bad && !pre_expired && !cmp_s.below_precondition
     && !cmp_s.over_regulation && !cmp_s.program_floating && en_q && !charge_timer_done_in)
    |=> state_q == CCS_CONST_CURRENT) else $error("precondition did not advance");
  status_on_a: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q inside {CCS_PRECOND, CCS_CONST_CURRENT} |-> ##1 !status_oe_n_out || state_q != $past(state_q))
    else $error("status not low while charging");
  float_pin_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cmp_s.program_floating |=> !(state_q inside {CCS_PRECOND, CCS_CONST_CURRENT, CCS_CONST_VOLTAGE}))
    else $error("charging with floating program pin");
  over_reg_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cmp_s.over_regulation |=> !drive_out.charge_on ##0 state_q != CCS_CONST_CURRENT)
    else $error("charging above regulation");
  cc_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(state_q == CCS_CONST_CURRENT) |-> $past(charge_timer_clear_out) || charge_timer_clear_out)
    else $error("charge timer not cleared on entry");
  cc_fault_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_CONST_CURRENT && charge_timer_done_in && !supply_bad && !cmp_s.over_regulation
     && !cmp_s.program_floating && en_q) |=> state_q == CCS_FAULT ##1 drive_out.timer_fault)
    else $error("charge timer fault missed");
  fault_exit_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_FAULT && !cmp_s.below_recharge && !supply_bad) |=> state_q == CCS_STANDBY)
    else $error("battery removal not honoured");

  sequence cc_entry_s;
    (state_q != CCS_CONST_CURRENT) ##1 (state_q == CCS_CONST_CURRENT);
  endsequence

  sequence charge_ok_s;
    !supply_bad && !cmp_s.over_regulation && !cmp_s.program_floating && en_q;
  endsequence

  cc_entry_clr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    cc_entry_s |-> charge_timer_clear_out)
    else $error("no clear pulse on constant current entry");
  status_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q inside {CCS_SHUTDOWN, CCS_STANDBY, CCS_COMPLETE} |-> status_oe_n_out)
    else $error("status pulled low while idle");
  shut_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    state_q == CCS_SHUTDOWN |-> charge_timer_clear_out && !drive_out.timer_fault)
    else $error("shutdown kept timer or fault");
  pre_expire_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_PRECOND && pre_expired) ##0 charge_ok_s |=> state_q == CCS_FAULT)
    else $error("precondition timeout missed");
  cv_term_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_CONST_VOLTAGE && term_done) ##0 charge_ok_s
    |=> state_q == (RECHARGE_EN ? CCS_COMPLETE : CCS_STANDBY))
    else $error("termination not taken");
  start_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q == CCS_STANDBY && !cmp_s.below_start)
    |=> !(state_q inside {CCS_PRECOND, CCS_CONST_CURRENT}))
    else $error("charge started above start level");
  enable_drop_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_q inside {CCS_PRECOND, CCS_CONST_CURRENT, CCS_CONST_VOLTAGE} && !en_q)
    |=> !drive_out.charge_on)
    else $error("charging without enable");
endmodule : ccs_sequencer

// file: tb/ccs_cmp_model.sv
`timescale 1ns/10ps
module ccs_cmp_model
  import ccs_pkg::*;
#(
  parameter int LOCKOUT_MV = 3000,
  parameter int HIGH_MV = 6500,
  parameter int PRE_MV = 2000,
  parameter int RCH_MV = 3450,
  parameter int REG_MV = 3600,
  parameter int HYS_MV = 100
) (
  // clock
  input wire logic clk_in,
  // analog levels
  input int supply_mv_in,
  input int bat_mv_in,
  input wire logic current_program_pin_open_in,
  input wire logic term_low_in,
  // comparator flags
  output ccs_pkg::ccs_cmp_t cmp_out
);
  import ccs_pkg::*;
  logic ovp_q = 1'b0;
  // trips above the limit, releases 150 mV lower
  always_ff @(posedge clk_in) begin
    ovp_q <= ovp_q ? (supply_mv_in > HIGH_MV - 150) : (supply_mv_in > HIGH_MV);
  end
  always_comb begin
    cmp_out.input_low_lockout = supply_mv_in < LOCKOUT_MV;
    cmp_out.input_high_lockout = ovp_q;
    cmp_out.headroom_ok = supply_mv_in >= bat_mv_in + 150;
    cmp_out.power_down = supply_mv_in <= bat_mv_in + 50;
    cmp_out.below_start = bat_mv_in < 3400;
    cmp_out.below_precondition = bat_mv_in < PRE_MV;
    cmp_out.below_recharge = bat_mv_in < RCH_MV;
    cmp_out.at_regulation = bat_mv_in >= REG_MV;
    cmp_out.over_regulation = bat_mv_in > REG_MV + HYS_MV;
    cmp_out.program_floating = current_program_pin_open_in;
    cmp_out.below_termination = term_low_in;
  end
endmodule : ccs_cmp_model

// file: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  import ccs_pkg::*;
  logic clk_in, rst_in, en, tdone, current_program_pin_open, term_low, clr_seen;
  int supply, bat, error_cnt, comparisons, i;
  logic [31:0] lfsr_q = 32'hA7FD;
  int bad[4];
  ccs_cmp_t cmp;
  ccs_drive_t drv;
  ccs_state_t st;
  logic clr, oe_n, so;
  ccs_cmp_model model (.clk_in(clk_in), .supply_mv_in(supply), .bat_mv_in(bat),
    .current_program_pin_open_in(current_program_pin_open), .term_low_in(term_low), .cmp_out(cmp));
  ccs_sequencer #(.PRE_TIMER_CYC(50), .FLASH_HALF_CYC(20), .TERM_FILT_CYC(10)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .cmp_in(cmp), .charge_enable_in(en),
    .charge_timer_done_in(tdone), .drive_out(drv), .charge_timer_clear_out(clr),
    .state_out(st), .status_o_out(so), .status_oe_n_out(oe_n));
  function automatic int rnd(input int span);
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return int'(lfsr_q[15:0]) % span;
  endfunction : rnd
  function automatic logic charging(input ccs_state_t s);
    return s inside {CCS_PRECOND, CCS_CONST_CURRENT, CCS_CONST_VOLTAGE};
  endfunction : charging
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask : step
  task automatic expect_st(input ccs_state_t s);
    for (int k = 0; k < 100 && st !== s; k++) begin
      step();
      clr_seen |= clr;
    end
    `CHK(st, s)
    `CHK(drv.charge_on, charging(s))
    `CHK(drv.precondition_current, s == CCS_PRECOND)
    `CHK(drv.voltage_mode, s == CCS_CONST_VOLTAGE)
    `CHK(so, 1'b0)
    if (s != CCS_FAULT) `CHK(oe_n, !charging(s))
  endtask : expect_st
  task automatic hold_st(input ccs_state_t s);
    repeat (12) step();
    `CHK(st, s)
  endtask : hold_st
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_in, en, tdone, current_program_pin_open, term_low, clr_seen} = 6'h20;
    supply = 0;
    bat = 3300;
    error_cnt = 0;
    comparisons = 0;
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    `CHK(st, CCS_SHUTDOWN)
    `CHK(clr, 1'b1)
    en = 1'b1;
    hold_st(CCS_SHUTDOWN);
    supply = 4300 + rnd(1500);
    bat = 1000 + rnd(900);
    expect_st(CCS_PRECOND);
    clr_seen = 1'b0;
    bat = 2100 + rnd(1000);
    expect_st(CCS_CONST_CURRENT);
    `CHK(clr_seen, 1'b1)
    bat = 3600;
    expect_st(CCS_CONST_VOLTAGE);
    term_low = 1'b1;
    expect_st(CCS_COMPLETE);
    term_low = 1'b0;
    bat = 3300;
    expect_st(CCS_CONST_CURRENT);
    tdone = 1'b1;
    expect_st(CCS_FAULT);
    `CHK(drv.timer_fault, 1'b1)
    tdone = 1'b0;
    supply = 0;
    expect_st(CCS_SHUTDOWN);
    `CHK(drv.timer_fault, 1'b0)
    bad = '{2900, 3400, 3330, 7000};
    for (i = 0; i < 4; i++) begin
      supply = 5000;
      expect_st(CCS_CONST_CURRENT);
      supply = bad[i];
      expect_st(CCS_SHUTDOWN);
      `CHK(drv.timer_fault, 1'b0)
    end
    supply = 6400;
    hold_st(CCS_SHUTDOWN);
    supply = 5000;
    current_program_pin_open = 1'b1;
    hold_st(CCS_STANDBY);
    current_program_pin_open = 1'b0;
    expect_st(CCS_CONST_CURRENT);
    en = 1'b0;
    expect_st(CCS_STANDBY);
    en = 1'b1;
    bat = 3800;
    hold_st(CCS_STANDBY);
    bat = 3420;
    hold_st(CCS_STANDBY);
    bat = 1500;
    expect_st(CCS_PRECOND);
    expect_st(CCS_FAULT);
    `CHK(drv.timer_fault, 1'b1)
    clr_seen = 1'b0;
    for (i = 0; i < 50; i++) begin
      step();
      clr_seen |= !oe_n;
    end
    `CHK(clr_seen, 1'b1)
    `CHK(st, CCS_FAULT)
    bat = 3500;
    expect_st(CCS_STANDBY);
    hold_st(CCS_STANDBY);
    bat = 1500;
    expect_st(CCS_PRECOND);
    wrap_up();
  end
endmodule : tb_top
